//--- hdl/ccpc_compare.sv
// Purpose: two compare channels with pwm entry, timer two base, register port
// Assumes: timer one count and converter enable come from logic on clk_i
// Notes: all outputs registered, so trigger shows one clock after equality
`timescale 1ns/1ns
module ccpc_compare
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic [15:0] timer_one_count_i,
  output logic timer_one_clear_o,
  input wire logic adc_enable_i,
  output logic adc_start_o,
  output logic ccp_one_pin_o,
  output logic ccp_one_pin_oe_o,
  output logic ccp_two_pin_a_o,
  output logic ccp_two_pin_a_oe_o,
  output logic ccp_two_pin_b_o,
  output logic ccp_two_pin_b_oe_o,
  output logic irq_o
);
  typedef struct packed {
    logic [1:0][7:0] ctrl;
    logic [1:0][7:0] cmpl;
    logic [1:0][7:0] cmph;
    logic [1:0] status;
    logic [1:0] mask;
    logic pin_sel;
    logic [7:0] period;
    logic [7:0] t2ctrl;
    logic [1:0] latch;
    logic [1:0] match_prev;
    logic [1:0] trig_prev;
    logic [9:0] base;
    logic [4:0] pre;
    logic [7:0] rdata;
    logic t1_clear;
    logic adc_start;
    logic irq;
    logic pin1;
    logic pin1_oe;
    logic pin2a;
    logic pin2a_oe;
    logic pin2b;
    logic pin2b_oe;
  } ccpc_cmp_state_t;

  ccpc_cmp_state_t s_r;
  ccpc_cmp_state_t s_nxt;

  logic [1:0][3:0] mode;
  logic [1:0] is_pwm;
  logic [1:0] cmp_mode;
  logic [1:0] match;
  logic [1:0] trig;
  logic [1:0] owns;
  logic [1:0] pin_val;
  logic [1:0] pwm_level;
  logic [1:0][7:0] duty_high;
  logic [4:0] pre_len;
  logic t2_on;
  logic step;
  logic period_end;
  logic [9:0] base_next;

  // per-channel decode, equality and pwm instance
  for (genvar c = 0; c < 2; c++)
  begin : g_chan
    assign mode[c] = s_r.ctrl[c][ccpc_pkg::CTRL_MODE_LSB +: 4];
    assign is_pwm[c] = (mode[c][3:2] == ccpc_pkg::MODE_PWM_TOP);
    // toggle, set, clear codes share the wider encoding
    assign cmp_mode[c] = (mode[c] == ccpc_pkg::MODE_TOGGLE) || (mode[c] == ccpc_pkg::MODE_SET) ||
                         (mode[c] == ccpc_pkg::MODE_CLEAR) || (mode[c] == ccpc_pkg::MODE_SWINT) ||
                         (mode[c] == ccpc_pkg::MODE_SPECIAL);
    // compared every clock, no sampling window
    assign match[c] = cmp_mode[c] && (timer_one_count_i == {s_r.cmph[c], s_r.cmpl[c]});
    assign trig[c] = match[c] && (mode[c] == ccpc_pkg::MODE_SPECIAL);
    // swint and special leave the pin to the port
    assign owns[c] = is_pwm[c] || (mode[c] == ccpc_pkg::MODE_TOGGLE) ||
                     (mode[c] == ccpc_pkg::MODE_SET) || (mode[c] == ccpc_pkg::MODE_CLEAR);
    assign pin_val[c] = is_pwm[c] ? pwm_level[c] : s_r.latch[c];

    ccpc_pwm_chan u_pwm
    (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .enable_i(is_pwm[c]),
      .period_end_i(period_end),
      .base_i(base_next),
      .duty_i({s_r.cmpl[c], s_r.ctrl[c][ccpc_pkg::CTRL_DUTY_LSB +: 2]}),
      .level_o(pwm_level[c]),
      .duty_high_o(duty_high[c])
    );
  end

  // timer two base: low two bits step per prescaled clock, top eight form the count
  assign t2_on = s_r.t2ctrl[ccpc_pkg::T2_ON_BIT];
  always_comb
  begin
    case (s_r.t2ctrl[ccpc_pkg::T2_PS_LSB +: 2])
      2'h0: pre_len = ccpc_pkg::PS_CYC_ONE;
      2'h1: pre_len = ccpc_pkg::PS_CYC_FOUR;
      default: pre_len = ccpc_pkg::PS_CYC_SIXTEEN;
    endcase
  end
  assign step = t2_on && (s_r.pre == pre_len - 5'h01);
  assign period_end = step && (s_r.base == {s_r.period, 2'h3});
  // channels see the coming base value, so the pwm level drops on the very edge the base reaches duty
  assign base_next = period_end ? 10'h000 : (step ? s_r.base + 10'h001 : s_r.base);

  // one next-state process for bus, compare actions, timer two and pins
  always_comb
  begin
    logic [1:0] set_ev;
    logic [1:0] ctrl_wr;
    set_ev = 2'h0;
    ctrl_wr = 2'h0;
    s_nxt = s_r;
    s_nxt.rdata = 8'h00;

    // register reads, data valid the following cycle
    if (rd_i)
    begin
      case (addr_i)
        ccpc_pkg::ADDR_CTRL_ONE: s_nxt.rdata = {2'h0, s_r.ctrl[0][5:0]};
        ccpc_pkg::ADDR_CTRL_TWO: s_nxt.rdata = {2'h0, s_r.ctrl[1][5:0]};
        ccpc_pkg::ADDR_CMPL_ONE: s_nxt.rdata = s_r.cmpl[0];
        ccpc_pkg::ADDR_CMPH_ONE: s_nxt.rdata = is_pwm[0] ? duty_high[0] : s_r.cmph[0];
        ccpc_pkg::ADDR_CMPL_TWO: s_nxt.rdata = s_r.cmpl[1];
        ccpc_pkg::ADDR_CMPH_TWO: s_nxt.rdata = is_pwm[1] ? duty_high[1] : s_r.cmph[1];
        ccpc_pkg::ADDR_STATUS: s_nxt.rdata = {6'h00, s_r.status};
        ccpc_pkg::ADDR_MASK: s_nxt.rdata = {6'h00, s_r.mask};
        ccpc_pkg::ADDR_PIN_SEL: s_nxt.rdata = {7'h00, s_r.pin_sel};
        ccpc_pkg::ADDR_PERIOD: s_nxt.rdata = s_r.period;
        ccpc_pkg::ADDR_T2CTRL: s_nxt.rdata = {5'h00, s_r.t2ctrl[2:0]};
        default: s_nxt.rdata = 8'h00;
      endcase
    end

    // register writes; high compare byte is read-only in pwm
    if (wr_i)
    begin
      case (addr_i)
        ccpc_pkg::ADDR_CTRL_ONE:
        begin
          s_nxt.ctrl[0] = {2'h0, wdata_i[5:0]};
          ctrl_wr[0] = 1'b1;
        end
        ccpc_pkg::ADDR_CTRL_TWO:
        begin
          s_nxt.ctrl[1] = {2'h0, wdata_i[5:0]};
          ctrl_wr[1] = 1'b1;
        end
        ccpc_pkg::ADDR_CMPL_ONE: s_nxt.cmpl[0] = wdata_i;
        ccpc_pkg::ADDR_CMPH_ONE: if (!is_pwm[0]) s_nxt.cmph[0] = wdata_i;
        ccpc_pkg::ADDR_CMPL_TWO: s_nxt.cmpl[1] = wdata_i;
        ccpc_pkg::ADDR_CMPH_TWO: if (!is_pwm[1]) s_nxt.cmph[1] = wdata_i;
        ccpc_pkg::ADDR_MASK: s_nxt.mask = wdata_i[1:0];
        ccpc_pkg::ADDR_PIN_SEL: s_nxt.pin_sel = wdata_i[0];
        ccpc_pkg::ADDR_PERIOD: s_nxt.period = wdata_i;
        ccpc_pkg::ADDR_T2CTRL: s_nxt.t2ctrl = {5'h00, wdata_i[2:0]};
        default: s_nxt.rdata = s_nxt.rdata;
      endcase
    end

    // match edge acts once per equality, not every clock it holds
    for (int c = 0; c < 2; c++)
    begin
      if (match[c] && !s_r.match_prev[c])
      begin
        set_ev[c] = 1'b1;
        case (mode[c])
          ccpc_pkg::MODE_TOGGLE: s_nxt.latch[c] = ~s_r.latch[c];
          ccpc_pkg::MODE_SET: s_nxt.latch[c] = 1'b1;
          ccpc_pkg::MODE_CLEAR: s_nxt.latch[c] = 1'b0;
          default: s_nxt.latch[c] = s_r.latch[c];
        endcase
      end
      // a zero control write parks the compare latch low
      if (ctrl_wr[c] && (wdata_i == ccpc_pkg::CTRL_RST))
        s_nxt.latch[c] = 1'b0;
    end
    s_nxt.match_prev = match;
    s_nxt.trig_prev = trig;

    // sticky flags: read clears, a new event in the same cycle wins
    if (rd_i && (addr_i == ccpc_pkg::ADDR_STATUS))
      s_nxt.status = set_ev;
    else
      s_nxt.status = s_r.status | set_ev;
    s_nxt.irq = |(s_nxt.status & s_nxt.mask);

    // clear request stays high only while the match holds; timer one acts on its own edge
    s_nxt.t1_clear = |trig;
    // conversion start is a single pulse on channel two trigger entry
    s_nxt.adc_start = trig[1] && !s_r.trig_prev[1] && adc_enable_i;

    // timer two time base
    if (!t2_on)
      s_nxt.pre = 5'h00;
    else if (step)
      s_nxt.pre = 5'h00;
    else
      s_nxt.pre = s_r.pre + 5'h01;
    s_nxt.base = base_next;

    // pin routing, channel two steered to one of two pins
    s_nxt.pin1 = pin_val[0];
    s_nxt.pin1_oe = owns[0];
    s_nxt.pin2a = pin_val[1] && !s_r.pin_sel;
    s_nxt.pin2a_oe = owns[1] && !s_r.pin_sel;
    s_nxt.pin2b = pin_val[1] && s_r.pin_sel;
    s_nxt.pin2b_oe = owns[1] && s_r.pin_sel;
  end

  // single state register; stops with clk_i, so nothing moves in sleep
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      s_r <= '0;
      s_r.ctrl <= {ccpc_pkg::CTRL_RST, ccpc_pkg::CTRL_RST};
      s_r.cmpl <= {ccpc_pkg::CMP_RST, ccpc_pkg::CMP_RST};
      s_r.cmph <= {ccpc_pkg::CMP_RST, ccpc_pkg::CMP_RST};
      s_r.mask <= ccpc_pkg::MASK_RST;
      s_r.period <= ccpc_pkg::PERIOD_RST;
      s_r.t2ctrl <= ccpc_pkg::T2CTRL_RST;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state register
  // clear request is separate from any overflow flag path
  assign timer_one_clear_o = s_r.t1_clear;
  assign adc_start_o = s_r.adc_start;
  assign rdata_o = s_r.rdata;
  assign irq_o = s_r.irq;
  assign ccp_one_pin_o = s_r.pin1;
  assign ccp_one_pin_oe_o = s_r.pin1_oe;
  assign ccp_two_pin_a_o = s_r.pin2a;
  assign ccp_two_pin_a_oe_o = s_r.pin2a_oe;
  assign ccp_two_pin_b_o = s_r.pin2b;
  assign ccp_two_pin_b_oe_o = s_r.pin2b_oe;

  // checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  sequence s_zero_ctrl_one;
    wr_i && (addr_i == ccpc_pkg::ADDR_CTRL_ONE) && (wdata_i == 8'h00);
  endsequence

  sequence s_swint_edge;
    (mode[0] == ccpc_pkg::MODE_SWINT) && match[0] && !s_r.match_prev[0];
  endsequence

  sequence s_period_wrap;
    period_end ##1 1'b1;
  endsequence

  AST_CLEAR_LATCH: assert property (s_zero_ctrl_one |=> !s_r.latch[0] ##1 !ccp_one_pin_o)
    else $error("latch not low after zero control write");

  AST_SWINT_FLAG: assert property (s_swint_edge |=> s_r.status[0])
    else $error("software interrupt match did not set flag");

  AST_SWINT_NO_PIN: assert property ((mode[0] == ccpc_pkg::MODE_SWINT) && !wr_i |=> !ccp_one_pin_oe_o)
    else $error("software interrupt mode drove the pin");

  AST_SPECIAL_NO_PIN: assert property ((mode[1] == ccpc_pkg::MODE_SPECIAL) |=> !ccp_two_pin_a_oe_o && !ccp_two_pin_b_oe_o)
    else $error("special event mode drove the pin");

  AST_SPECIAL_CLEAR: assert property (trig[0] |=> timer_one_clear_o)
    else $error("special match gave no timer clear");

  AST_CLEAR_NEEDS_MATCH: assert property (timer_one_clear_o |-> $past(trig[0] || trig[1]))
    else $error("timer clear without a live match");

  AST_ADC_CHAN_TWO: assert property (adc_start_o |-> $past(trig[1]) && $past(adc_enable_i) ##1 !adc_start_o)
    else $error("conversion start without channel two trigger");

  AST_PIN_SELECT: assert property (ccp_two_pin_b_oe_o |-> !ccp_two_pin_a_oe_o && $past(s_r.pin_sel))
    else $error("channel two drove the unselected pin");

  AST_PWM_WRAP: assert property (s_period_wrap |-> s_r.base == 10'h000)
    else $error("time base did not wrap at period end");

  AST_FLAG_SET_WINS: assert property (s_swint_edge and (rd_i && addr_i == ccpc_pkg::ADDR_STATUS) |=> s_r.status[0])
    else $error("status read lost a same-cycle event");
endmodule : ccpc_compare

//--- inc/ccpc_pkg.sv
// Purpose: shared constants for the compare / pwm-entry block
// Assumes: 8-bit register port, word index equals address
// Notes: mode codes and field positions live here only
package ccpc_pkg;
  // register indices
  localparam logic [3:0] ADDR_CTRL_ONE = 4'h0;
  localparam logic [3:0] ADDR_CTRL_TWO = 4'h1;
  localparam logic [3:0] ADDR_CMPL_ONE = 4'h2;
  localparam logic [3:0] ADDR_CMPH_ONE = 4'h3;
  localparam logic [3:0] ADDR_CMPL_TWO = 4'h4;
  localparam logic [3:0] ADDR_CMPH_TWO = 4'h5;
  localparam logic [3:0] ADDR_STATUS = 4'h6;
  localparam logic [3:0] ADDR_MASK = 4'h7;
  localparam logic [3:0] ADDR_PIN_SEL = 4'h8;
  localparam logic [3:0] ADDR_PERIOD = 4'h9;
  localparam logic [3:0] ADDR_T2CTRL = 4'ha;
  // mode codes in ccp_control[3:0]
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] MODE_TOGGLE = 4'h2;
  localparam logic [3:0] MODE_SET = 4'h8;
  localparam logic [3:0] MODE_CLEAR = 4'h9;
  localparam logic [3:0] MODE_SWINT = 4'ha;
  localparam logic [3:0] MODE_SPECIAL = 4'hb;
  localparam logic [1:0] MODE_PWM_TOP = 2'h3;
  // field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_DUTY_LSB = 4;
  localparam int T2_PS_LSB = 0;
  localparam int T2_ON_BIT = 2;
  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] CMP_RST = 8'h00;
  localparam logic [7:0] PERIOD_RST = 8'hff;
  localparam logic [7:0] T2CTRL_RST = 8'h00;
  localparam logic [1:0] MASK_RST = 2'h0;
  // timer two prescale lengths in system clocks per base step
  localparam logic [4:0] PS_CYC_ONE = 5'h01;
  localparam logic [4:0] PS_CYC_FOUR = 5'h04;
  localparam logic [4:0] PS_CYC_SIXTEEN = 5'h10;
endpackage : ccpc_pkg

//--- hdl/ccpc_pwm_chan.sv
// Purpose: one pwm channel with double-buffered 10-bit duty
// Assumes: base_i is the next value of the shared 10-bit time base, period_end_i one cycle wide
// Notes: duty above the period leaves the level unchanged
`timescale 1ns/1ns
module ccpc_pwm_chan
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic enable_i,
  input wire logic period_end_i,
  input wire logic [9:0] base_i,
  input wire logic [9:0] duty_i,
  output logic level_o,
  output logic [7:0] duty_high_o
);
  typedef struct packed {
    logic [9:0] duty_sh;
    logic level;
  } ccpc_pwm_state_t;

  ccpc_pwm_state_t s_r;
  ccpc_pwm_state_t s_nxt;

  // latch duty at period end, set pin unless duty is zero, clear as the base reaches duty
  // comparing the coming base keeps the high time at exactly duty steps, not one clock more
  always_comb
  begin
    s_nxt = s_r;
    if (!enable_i)
    begin
      s_nxt.level = 1'b0;
    end
    else if (period_end_i)
    begin
      s_nxt.duty_sh = duty_i;
      s_nxt.level = (duty_i != 10'h000);
    end
    else if (base_i == s_r.duty_sh)
    begin
      s_nxt.level = 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign level_o = s_r.level;
  assign duty_high_o = s_r.duty_sh[9:2];
endmodule : ccpc_pwm_chan

//--- sim/ccpc_timer_model.sv
// Purpose: behavioural timer one beside the compare block
// Assumes: count ticks every TICK_DIV system clocks, synchronous to clk_i
// Notes: load_i lets the bench jump near a compare value
`timescale 1ns/1ns
module ccpc_timer_model
#(
  parameter int TICK_DIV = 8
)
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic clear_i,
  input wire logic load_i,
  input wire logic [15:0] load_val_i,
  output logic [15:0] count_o,
  output logic overflow_o
);
  int div_cnt;

  // synchronized counter, ticking once every TICK_DIV system clocks
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      count_o <= 16'h0000;
      overflow_o <= 1'b0;
      div_cnt <= 0;
    end
    else if (load_i)
    begin
      count_o <= load_val_i;
      overflow_o <= 1'b0;
      div_cnt <= 0;
    end
    else if (div_cnt == TICK_DIV - 1)
    begin
      div_cnt <= 0;
      // clear looked at only on a tick, so a dropped request is lost
      if (clear_i)
        count_o <= 16'h0000;
      else
        count_o <= count_o + 16'h0001;
      // only a real wrap flags overflow, not a trigger clear
      if (!clear_i && count_o == 16'hffff)
        overflow_o <= 1'b1;
    end
    else
      div_cnt <= div_cnt + 1;
  end
endmodule : ccpc_timer_model

//--- sim/tb.sv
// Purpose: self-checking bench for the compare / pwm-entry block
// Assumes: timer one model ticks every 8 clocks, slow enough to cancel a clear
// Notes: each scenario task drives the block and judges its answers
`timescale 1ns/1ns
module tb;
  logic clk_i, reset_i, wr_i, rd_i, adc_enable_i, load_i;
  logic clear, ovf, adc_start, p1, p1_oe, pa, pa_oe, pb, pb_oe, irq;
  logic [3:0] addr_i;
  logic [7:0] wdata_i, rdata_o;
  logic [15:0] count, load_val;
  int err_total, check_count;

  ccpc_compare dut (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .timer_one_count_i(count), .timer_one_clear_o(clear),
    .adc_enable_i(adc_enable_i), .adc_start_o(adc_start), .ccp_one_pin_o(p1), .ccp_one_pin_oe_o(p1_oe),
    .ccp_two_pin_a_o(pa), .ccp_two_pin_a_oe_o(pa_oe), .ccp_two_pin_b_o(pb), .ccp_two_pin_b_oe_o(pb_oe),
    .irq_o(irq));
  ccpc_timer_model #(.TICK_DIV(8)) timer (.clk_i(clk_i), .reset_i(reset_i), .clear_i(clear), .load_i(load_i),
    .load_val_i(load_val), .count_o(count), .overflow_o(ovf));

  // 250 MHz system clock
  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk16

  task automatic chk1(input string what, input logic exp, input logic got);
    chk16(what, {15'h0000, exp}, {15'h0000, got});
  endtask : chk1

  // sample a little after the edge so its updates have landed
  task automatic step();
    @(posedge clk_i);
    #1;
  endtask : step

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask : rd

  task automatic cmpset(input logic [3:0] a, input logic [15:0] v);
    wr(a, v[7:0]);
    wr(a + 4'h1, v[15:8]);
  endtask : cmpset

  task automatic tload(input logic [15:0] v);
    @(posedge clk_i);
    load_i <= 1'b1;
    load_val <= v;
    @(posedge clk_i);
    load_i <= 1'b0;
  endtask : tload

  task automatic t_reset();
    logic [7:0] d;
    for (int a = 0; a < 12; a++)
    begin
      rd(a[3:0], d);
      chk16("reg reset", {8'h00, (a[3:0] == ccpc_pkg::ADDR_PERIOD) ? ccpc_pkg::PERIOD_RST : 8'h00}, {8'h00, d});
    end
    chk1("irq reset", 1'b0, irq);
    $display("test reset done");
  endtask : t_reset

  task automatic t_swint();
    logic [7:0] d;
    cmpset(ccpc_pkg::ADDR_CMPL_ONE, 16'h0020);
    wr(ccpc_pkg::ADDR_CTRL_ONE, {4'h0, ccpc_pkg::MODE_SWINT});
    wr(ccpc_pkg::ADDR_MASK, 8'h01);
    tload(16'h001e);
    for (int n = 0; n < 80 && irq !== 1'b1; n++) step();
    chk1("swint irq", 1'b1, irq);
    chk1("swint pin drive", 1'b0, p1_oe);
    wr(ccpc_pkg::ADDR_MASK, 8'h00);
    step();
    chk1("masked irq", 1'b0, irq);
    wr(ccpc_pkg::ADDR_MASK, 8'h01);
    step();
    chk1("unmasked irq", 1'b1, irq);
    rd(ccpc_pkg::ADDR_STATUS, d);
    chk16("status", 16'h0001, {8'h00, d});
    step();
    chk1("irq after read", 1'b0, irq);
    rd(ccpc_pkg::ADDR_STATUS, d);
    chk16("status cleared", 16'h0000, {8'h00, d});
    // status read in the very cycle of a new match: the event must survive the clear
    tload(16'h001f);
    repeat (7) @(posedge clk_i);
    rd(ccpc_pkg::ADDR_STATUS, d);
    chk16("status at event", 16'h0000, {8'h00, d});
    rd(ccpc_pkg::ADDR_STATUS, d);
    chk16("status kept", 16'h0001, {8'h00, d});
    $display("test swint done");
  endtask : t_swint

  task automatic t_special(input logic en);
    logic [7:0] d;
    logic [15:0] trig = 16'h0000;
    logic seen = 1'b0;
    int pulses = 0;
    adc_enable_i <= en;
    cmpset(ccpc_pkg::ADDR_CMPL_TWO, 16'h0010);
    wr(ccpc_pkg::ADDR_CTRL_TWO, {4'h0, ccpc_pkg::MODE_SPECIAL});
    tload(16'h000e);
    for (int n = 0; n < 80 && count !== 16'h0000; n++)
    begin
      step();
      pulses += adc_start;
      if (!seen) trig = count;
      seen |= (clear === 1'b1);
    end
    chk16("count at trigger", 16'h0010, trig);
    chk16("timer cleared", 16'h0000, count);
    chk1("overflow flag", 1'b0, ovf);
    chk16("adc starts", {15'h0000, en}, 16'(pulses));
    chk1("pin a drive", 1'b0, pa_oe);
    chk1("pin b drive", 1'b0, pb_oe);
    rd(ccpc_pkg::ADDR_STATUS, d);
    chk16("special flag", 16'h0002, {8'h00, d});
    wr(ccpc_pkg::ADDR_CTRL_TWO, 8'h00);
    $display("test special done");
  endtask : t_special

  task automatic t_cancel();
    logic [7:0] d;
    cmpset(ccpc_pkg::ADDR_CMPL_ONE, 16'h0040);
    wr(ccpc_pkg::ADDR_CTRL_ONE, {4'h0, ccpc_pkg::MODE_SPECIAL});
    tload(16'h003e);
    for (int n = 0; n < 80 && clear !== 1'b1; n++) step();
    // move the compare value far away, so no fresh match hides a lost cancel
    wr(ccpc_pkg::ADDR_CMPH_ONE, 8'h12);
    repeat (12) step();
    chk1("timer not cleared", 1'b1, count >= 16'h0040);
    rd(ccpc_pkg::ADDR_STATUS, d);
    wr(ccpc_pkg::ADDR_CTRL_ONE, 8'h00);
    $display("test cancel done");
  endtask : t_cancel

  task automatic t_outputs();
    logic [3:0] modes [5] = '{ccpc_pkg::MODE_SET, ccpc_pkg::MODE_CLEAR, ccpc_pkg::MODE_TOGGLE,
      ccpc_pkg::MODE_TOGGLE, ccpc_pkg::MODE_SET};
    logic lvl [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
    logic [7:0] d;
    cmpset(ccpc_pkg::ADDR_CMPL_ONE, 16'h0030);
    foreach (modes[i])
    begin
      wr(ccpc_pkg::ADDR_CTRL_ONE, {4'h0, modes[i]});
      tload(16'h002f);
      for (int n = 0; n < 40 && irq !== 1'b1; n++) step();
      repeat (2) step();
      chk1("pin level", lvl[i], p1);
      chk1("pin drive", 1'b1, p1_oe);
      rd(ccpc_pkg::ADDR_STATUS, d);
      chk16("match flag", 16'h0001, {8'h00, d});
    end
    wr(ccpc_pkg::ADDR_CTRL_ONE, 8'h00);
    step();
    chk1("latch after zero write", 1'b0, p1);
    $display("test outputs done");
  endtask : t_outputs

  task automatic t_pinsel();
    logic [7:0] d;
    cmpset(ccpc_pkg::ADDR_CMPL_TWO, 16'h0050);
    wr(ccpc_pkg::ADDR_PIN_SEL, 8'h01);
    wr(ccpc_pkg::ADDR_CTRL_TWO, {4'h0, ccpc_pkg::MODE_SET});
    tload(16'h004f);
    for (int n = 0; n < 40 && pb !== 1'b1; n++) step();
    chk1("pin b level", 1'b1, pb);
    chk1("pin b drive", 1'b1, pb_oe);
    chk1("pin a drive", 1'b0, pa_oe);
    chk1("pin a level", 1'b0, pa);
    // steer the set output back to pin a
    wr(ccpc_pkg::ADDR_PIN_SEL, 8'h00);
    step();
    chk1("pin a level", 1'b1, pa);
    chk1("pin a drive", 1'b1, pa_oe);
    chk1("pin b drive", 1'b0, pb_oe);
    wr(ccpc_pkg::ADDR_CTRL_TWO, 8'h00);
    rd(ccpc_pkg::ADDR_STATUS, d);
    $display("test pinsel done");
  endtask : t_pinsel

  // duty 8 of a 16-step period, so half of any whole-period window is high
  task automatic t_pwm();
    logic [7:0] d;
    int hi = 0;
    wr(ccpc_pkg::ADDR_PERIOD, 8'h03);
    wr(ccpc_pkg::ADDR_CMPL_ONE, 8'h02);
    wr(ccpc_pkg::ADDR_CTRL_ONE, 8'h0c);
    wr(ccpc_pkg::ADDR_CMPH_ONE, 8'h77);
    // prescale codes 0, 1 and 2; 256 clocks hold whole periods of 16, 64 or 256 clocks
    for (int ps = 0; ps < 3; ps++)
    begin
      wr(ccpc_pkg::ADDR_T2CTRL, 8'h04 | 8'(ps));
      repeat (300) step();
      hi = 0;
      repeat (256)
      begin
        step();
        hi += p1;
      end
      chk16("pwm high cycles", 16'h0080, 16'(hi));
    end
    chk1("pwm drive", 1'b1, p1_oe);
    rd(ccpc_pkg::ADDR_CMPH_ONE, d);
    chk16("latched duty", 16'h0002, {8'h00, d});
    wr(ccpc_pkg::ADDR_CTRL_ONE, 8'h00);
    wr(ccpc_pkg::ADDR_T2CTRL, 8'h00);
    $display("test pwm done");
  endtask : t_pwm

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize

  // main sequence
  initial
  begin
    reset_i = 1'b1;
    {wr_i, rd_i, adc_enable_i, load_i} = 4'h0;
    addr_i = 4'h0;
    wdata_i = 8'h00;
    load_val = 16'h0000;
    err_total = 0;
    check_count = 0;
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    t_reset();
    t_swint();
    t_special(1'b1);
    t_special(1'b0);
    t_cancel();
    t_outputs();
    t_pinsel();
    t_pwm();
    summarize();
  end

  // hang guard, far beyond the few thousand cycles the tests need
  initial
  begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    $display("watchdog expired");
    summarize();
  end
endmodule : tb
